// ==== rtl/scwd_decoder.sv ====
// Serial command word decoder for a frequency synthesizer.
// Assumes link pins are asynchronous to mclk_i and much slower than it.
//
// Function
// RQ1: Word bits 0 to 23 hold an unsigned frequency or channel value.
// RQ2: Bits 24 to 27 give n and the value is multiplied by ten to the n.
// RQ3: Bits 28 to 31 pick the one register that receives the scaled value.
// RQ4: Code 0 is channel, 1 start, 2 stop, 3 step and 4 reference.
// RQ5: The host sends only those five codes; any other code writes no register and pulses bad_code_o here.
// RQ6: Bits are sampled on serial clock rising edges while select is low.
// RQ7: Select rising after exactly 32 bits latches the word for decoding.
// RQ8: Operating frequency is start plus channel times step.
// RQ9: The word arrives most significant bit first, value bit 0 last.
`timescale 1ns/1ps
module scwd_decoder (
    input  wire logic                          mclk_i,
    input  wire logic                          rst_n_i,
    input  wire logic                          select_n_i,
    input  wire logic                          serial_in_i,
    input  wire logic                          serial_clock_i,
    output logic [scwd_pkg::SCALED_W-1:0]      channel_o,
    output logic [scwd_pkg::SCALED_W-1:0]      start_o,
    output logic [scwd_pkg::SCALED_W-1:0]      stop_o,
    output logic [scwd_pkg::SCALED_W-1:0]      step_o,
    output logic [scwd_pkg::SCALED_W-1:0]      ref_o,
    output logic [scwd_pkg::SCALED_W-1:0]      freq_o,
    output logic                               update_o,
    output logic                               bad_code_o
);

    // ==========================================
    // Pin synchronisers
    logic [1:0] sel_sync_reg;
    logic [1:0] dat_sync_reg;
    logic [1:0] clk_sync_reg;
    logic       clk_prev_reg;
    logic       sel_prev_reg;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sel_sync_reg <= 2'h3;
            dat_sync_reg <= 2'h0;
            clk_sync_reg <= 2'h0;
            clk_prev_reg <= 1'b0;
            sel_prev_reg <= 1'b1;
        end else begin
            sel_sync_reg <= {sel_sync_reg[0], select_n_i};
            dat_sync_reg <= {dat_sync_reg[0], serial_in_i};
            clk_sync_reg <= {clk_sync_reg[0], serial_clock_i};
            clk_prev_reg <= clk_sync_reg[1];
            sel_prev_reg <= sel_sync_reg[1];
        end
    end

    logic clk_rise;
    logic sel_rise;
    logic sel_low;
    assign clk_rise = clk_sync_reg[1] & ~clk_prev_reg;
    assign sel_rise = sel_sync_reg[1] & ~sel_prev_reg;
    assign sel_low  = ~sel_sync_reg[1];

    // ==========================================
    // Shift register and bit counter
    logic [scwd_pkg::WORD_W-1:0] shift_reg;
    logic [scwd_pkg::WORD_W-1:0] shift_next;
    logic [scwd_pkg::CNT_W-1:0]  count_reg;
    logic [scwd_pkg::CNT_W-1:0]  count_next;
    logic                        latch;

    always_comb begin
        shift_next = shift_reg;
        count_next = count_reg;
        latch      = 1'b0;
        if (sel_rise) begin
            latch      = (count_reg == scwd_pkg::BITS_PER_WORD); // RQ7
            count_next = 6'h0;
        end else if (sel_low && clk_rise) begin
            shift_next = {shift_reg[scwd_pkg::WORD_W-2:0], dat_sync_reg[1]}; // RQ6 RQ9
            if (count_reg != 6'h3F) begin
                count_next = count_reg + 6'h1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            shift_reg <= 32'h0;
            count_reg <= 6'h0;
        end else begin
            shift_reg <= shift_next;
            count_reg <= count_next;
        end
    end

    // ==========================================
    // Scaling and routing
    scwd_scale_if scale ();

    scwd_scaler u_scaler (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .sc      (scale)
    );

    scwd_pkg::scwd_state_e           state_reg;
    scwd_pkg::scwd_state_e           state_next;
    logic [scwd_pkg::CODE_W-1:0]     code_reg;
    logic [scwd_pkg::CODE_W-1:0]     code_next;
    logic [scwd_pkg::VAL_W-1:0]      val_reg;
    logic [scwd_pkg::VAL_W-1:0]      val_next;
    logic [scwd_pkg::EXP_W-1:0]      exp_reg;
    logic [scwd_pkg::EXP_W-1:0]      exp_next;
    logic                            go_reg;
    logic                            go_next;
    logic [scwd_pkg::SCALED_W-1:0]   chan_reg;
    logic [scwd_pkg::SCALED_W-1:0]   chan_next;
    logic [scwd_pkg::SCALED_W-1:0]   strt_reg;
    logic [scwd_pkg::SCALED_W-1:0]   strt_next;
    logic [scwd_pkg::SCALED_W-1:0]   stop_reg;
    logic [scwd_pkg::SCALED_W-1:0]   stop_next;
    logic [scwd_pkg::SCALED_W-1:0]   step_reg;
    logic [scwd_pkg::SCALED_W-1:0]   step_next;
    logic [scwd_pkg::SCALED_W-1:0]   refr_reg;
    logic [scwd_pkg::SCALED_W-1:0]   refr_next;
    logic [scwd_pkg::SCALED_W-1:0]   freq_reg;
    logic [scwd_pkg::SCALED_W-1:0]   freq_next;
    logic [2*scwd_pkg::SCALED_W-1:0] product;
    logic                            upd_reg;
    logic                            upd_next;
    logic                            bad_reg;
    logic                            bad_next;

    assign scale.start = go_reg;
    assign scale.value = val_reg;
    assign scale.expo  = exp_reg;
    assign product     = chan_reg * step_reg;

    always_comb begin
        state_next = state_reg;
        code_next  = code_reg;
        val_next   = val_reg;
        exp_next   = exp_reg;
        go_next    = 1'b0;
        chan_next  = chan_reg;
        strt_next  = strt_reg;
        stop_next  = stop_reg;
        step_next  = step_reg;
        refr_next  = refr_reg;
        upd_next   = 1'b0;
        bad_next   = 1'b0;
        freq_next  = strt_reg + product[scwd_pkg::SCALED_W-1:0]; // RQ8
        unique case (state_reg)
            scwd_pkg::SCWD_LISTEN: begin
                if (latch) begin
                    val_next   = shift_reg[scwd_pkg::VAL_LSB +: scwd_pkg::VAL_W]; // RQ1
                    exp_next   = shift_reg[scwd_pkg::EXP_LSB +: scwd_pkg::EXP_W]; // RQ2
                    code_next  = shift_reg[scwd_pkg::CODE_LSB +: scwd_pkg::CODE_W]; // RQ3
                    go_next    = 1'b1;
                    state_next = scwd_pkg::SCWD_SCALE;
                end
            end
            scwd_pkg::SCWD_SCALE: begin
                if (scale.done) begin
                    state_next = scwd_pkg::SCWD_LISTEN;
                    upd_next   = 1'b1;
                    unique case (code_reg) // RQ4
                        scwd_pkg::CODE_CHANNEL: chan_next = scale.result;
                        scwd_pkg::CODE_START:   strt_next = scale.result;
                        scwd_pkg::CODE_STOP:    stop_next = scale.result;
                        scwd_pkg::CODE_STEP:    step_next = scale.result;
                        scwd_pkg::CODE_REF:     refr_next = scale.result;
                        default: begin
                            upd_next = 1'b0;
                            bad_next = 1'b1; // RQ5
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_reg <= scwd_pkg::SCWD_LISTEN;
            code_reg  <= 4'h0;
            val_reg   <= 24'h0;
            exp_reg   <= 4'h0;
            go_reg    <= 1'b0;
            chan_reg  <= scwd_pkg::RST_CHANNEL;
            strt_reg  <= scwd_pkg::RST_START;
            stop_reg  <= scwd_pkg::RST_STOP;
            step_reg  <= scwd_pkg::RST_STEP;
            refr_reg  <= scwd_pkg::RST_REF;
            freq_reg  <= 74'h0;
            upd_reg   <= 1'b0;
            bad_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            code_reg  <= code_next;
            val_reg   <= val_next;
            exp_reg   <= exp_next;
            go_reg    <= go_next;
            chan_reg  <= chan_next;
            strt_reg  <= strt_next;
            stop_reg  <= stop_next;
            step_reg  <= step_next;
            refr_reg  <= refr_next;
            freq_reg  <= freq_next;
            upd_reg   <= upd_next;
            bad_reg   <= bad_next;
        end
    end

    // ==========================================
    // Outputs
    assign channel_o  = chan_reg;
    assign start_o    = strt_reg;
    assign stop_o     = stop_reg;
    assign step_o     = step_reg;
    assign ref_o      = refr_reg;
    assign freq_o     = freq_reg;
    assign update_o   = upd_reg;
    assign bad_code_o = bad_reg;

endmodule

// ==== rtl/scwd_pkg.sv ====
// Constants and helpers for the synthesizer command word decoder.
// Assumes a single system clock domain; the serial link is sampled.
package scwd_pkg;

    // ==========================================
    // Command word layout
    localparam int WORD_W      = 32;
    localparam int VAL_LSB     = 0;
    localparam int VAL_W       = 24;
    localparam int EXP_LSB     = 24;
    localparam int EXP_W       = 4;
    localparam int CODE_LSB    = 28;
    localparam int CODE_W      = 4;
    localparam int CNT_W       = 6;
    localparam logic [5:0] BITS_PER_WORD = 6'h20;

    // Value times ten to the fifteenth still fits in this width
    localparam int SCALED_W    = 74;

    // ==========================================
    // Routing codes
    localparam logic [3:0] CODE_CHANNEL = 4'h0;
    localparam logic [3:0] CODE_START   = 4'h1;
    localparam logic [3:0] CODE_STOP    = 4'h2;
    localparam logic [3:0] CODE_STEP    = 4'h3;
    localparam logic [3:0] CODE_REF     = 4'h4;

    // ==========================================
    // Preset values after reset
    localparam logic [SCALED_W-1:0] RST_CHANNEL = 74'h0;
    localparam logic [SCALED_W-1:0] RST_START   = 74'h0;
    localparam logic [SCALED_W-1:0] RST_STOP    = 74'h0;
    localparam logic [SCALED_W-1:0] RST_STEP    = 74'h0;
    localparam logic [SCALED_W-1:0] RST_REF     = 74'h0;

    // ==========================================
    // Main sequencer states
    typedef enum logic [0:0] {
        SCWD_LISTEN = 1'b0,
        SCWD_SCALE  = 1'b1
    } scwd_state_e;

    // Multiply by ten with shifts and one add
    function automatic logic [SCALED_W-1:0] times_ten(input logic [SCALED_W-1:0] a);
        times_ten = (a << 3) + (a << 1);
    endfunction

endpackage

// ==== rtl/scwd_scale_if.sv ====
// Request and answer signals between the decoder and its scaler.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface scwd_scale_if;
    logic                          start;
    logic [scwd_pkg::VAL_W-1:0]    value;
    logic [scwd_pkg::EXP_W-1:0]    expo;
    logic                          done;
    logic [scwd_pkg::SCALED_W-1:0] result;

    modport req (output start, output value, output expo, input done, input result);
    modport scl (input start, input value, input expo, output done, output result);
endinterface

// ==== rtl/scwd_scaler.sv ====
// Scales a 24-bit value by ten to a 4-bit exponent, one factor per cycle.
// Assumes start is a single-cycle pulse issued only while idle.
`timescale 1ns/1ps
module scwd_scaler (
    input  wire logic  mclk_i,
    input  wire logic  rst_n_i,
    scwd_scale_if.scl  sc
);

    logic                          busy_reg;
    logic                          busy_next;
    logic [scwd_pkg::EXP_W-1:0]    left_reg;
    logic [scwd_pkg::EXP_W-1:0]    left_next;
    logic [scwd_pkg::SCALED_W-1:0] acc_reg;
    logic [scwd_pkg::SCALED_W-1:0] acc_next;
    logic                          done_reg;
    logic                          done_next;

    // ==========================================
    // Repeated times-ten
    always_comb begin
        busy_next = busy_reg;
        left_next = left_reg;
        acc_next  = acc_reg;
        done_next = 1'b0;
        if (!busy_reg) begin
            if (sc.start) begin
                busy_next = 1'b1;
                left_next = sc.expo;
                acc_next  = {{(scwd_pkg::SCALED_W-scwd_pkg::VAL_W){1'b0}}, sc.value};
            end
        end else if (left_reg != 4'h0) begin
            acc_next  = scwd_pkg::times_ten(acc_reg); // RQ2
            left_next = left_reg - 4'h1;
        end else begin
            busy_next = 1'b0;
            done_next = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            busy_reg <= 1'b0;
            left_reg <= 4'h0;
            acc_reg  <= 74'h0;
            done_reg <= 1'b0;
        end else begin
            busy_reg <= busy_next;
            left_reg <= left_next;
            acc_reg  <= acc_next;
            done_reg <= done_next;
        end
    end

    assign sc.done   = done_reg;
    assign sc.result = acc_reg;

endmodule

// ==== tb/scwd_props.sv ====
// Checker for the command word decoder outputs.
// Assumes it is bound to scwd_decoder and sees only its ports.
`timescale 1ns/1ps
module scwd_props (
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic        select_n_i,
    input wire logic [73:0] channel_o,
    input wire logic [73:0] start_o,
    input wire logic [73:0] stop_o,
    input wire logic [73:0] step_o,
    input wire logic [73:0] ref_o,
    input wire logic [73:0] freq_o,
    input wire logic        update_o,
    input wire logic        bad_code_o
);
    // ==========================================
    // Helpers
    logic [73:0] f_exp;
    assign f_exp = start_o + channel_o * step_o;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_no_upd8;
        !update_o [*8];
    endsequence
    sequence s_no_bad8;
        !bad_code_o [*8];
    endsequence
    sequence s_sel_idle;
        select_n_i && $past(select_n_i, 6);
    endsequence
    // ==========================================
    // Properties
    property p_upd_pulse; update_o |=> s_no_upd8; endproperty
    property p_bad_pulse; bad_code_o |=> s_no_bad8; endproperty
    property p_excl; !(update_o && bad_code_o); endproperty
    property p_bad_nowrite;
        bad_code_o |-> $stable(channel_o) && $stable(start_o) && $stable(stop_o)
            && $stable(step_o) && $stable(ref_o);
    endproperty
    property p_quiet;
        !update_o |-> $stable({channel_o, start_o, stop_o, step_o, ref_o});
    endproperty
    property p_one_reg;
        update_o |-> $onehot0({$changed(channel_o), $changed(start_o), $changed(stop_o),
            $changed(step_o), $changed(ref_o)});
    endproperty
    property p_freq; freq_o == $past(f_exp); endproperty
    property p_after_sel; (update_o || bad_code_o) |-> s_sel_idle; endproperty
    a_upd_pulse: assert property (p_upd_pulse) else $error("update pulse too long");
    a_bad_pulse: assert property (p_bad_pulse) else $error("bad code pulse too long");
    a_excl: assert property (p_excl) else $error("update and bad code together");
    a_bad_nowrite: assert property (p_bad_nowrite) else $error("reserved code wrote");
    a_quiet: assert property (p_quiet) else $error("register moved without update");
    a_one_reg: assert property (p_one_reg) else $error("several registers written");
    a_freq: assert property (p_freq) else $error("frequency sum wrong");
    a_after_sel: assert property (p_after_sel) else $error("result before select rose");
endmodule
bind scwd_decoder scwd_props u_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .select_n_i(select_n_i),
    .channel_o(channel_o), .start_o(start_o), .stop_o(stop_o), .step_o(step_o),
    .ref_o(ref_o), .freq_o(freq_o), .update_o(update_o), .bad_code_o(bad_code_o));

// ==== tb/scwd_host.sv ====
// Host model shifting command words into the serial port.
// Assumes the bench calls send; moves only after mclk_i rising edges.
`timescale 1ns/1ps
module scwd_host (
    input  wire logic mclk_i,
    output logic      select_n_o,
    output logic      serial_o,
    output logic      sclk_o
);
    initial begin
        select_n_o = 1'b1;
        serial_o = 1'b0;
        sclk_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // ==========================================
    // Frame: a stray clock while deselected, then nb bits MSB first
    task automatic send(input logic [31:0] w, input int nb);
        tick(1);
        sclk_o <= 1'b1;
        tick(10);
        sclk_o <= 1'b0;
        tick(10);
        select_n_o <= 1'b0;
        tick(5);
        for (int i = 31; i > 31 - nb; i--) begin
            serial_o <= w[i];
            tick(10);
            sclk_o <= 1'b1;
            tick(10);
            sclk_o <= 1'b0;
        end
        tick(5);
        select_n_o <= 1'b1;
        serial_o <= ~serial_o;
    endtask
endmodule

// ==== tb/synth_command_word_decoder_tb_top.sv ====
// Self-checking bench for the command word decoder.
// Assumes scwd_host drives the link pins and a model predicts registers.
`timescale 1ns/1ps
module synth_command_word_decoder_tb_top;
    logic        mclk_i = 1'b0;
    logic        rst_n_i;
    logic        select_n_i;
    logic        serial_in_i;
    logic        serial_clock_i;
    logic [73:0] channel_o, start_o, stop_o, step_o, ref_o, freq_o;
    logic        update_o, bad_code_o;
    logic [73:0] mdl [5];
    int          num_errors = 0;
    int          total_checks = 0;
    int          seed = 32'h10A4E77D;
    always #2 mclk_i = ~mclk_i;
    scwd_decoder dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .select_n_i(select_n_i),
        .serial_in_i(serial_in_i), .serial_clock_i(serial_clock_i), .channel_o(channel_o),
        .start_o(start_o), .stop_o(stop_o), .step_o(step_o), .ref_o(ref_o),
        .freq_o(freq_o), .update_o(update_o), .bad_code_o(bad_code_o));
    scwd_host host (.mclk_i(mclk_i), .select_n_o(select_n_i), .serial_o(serial_in_i),
        .sclk_o(serial_clock_i));
    // ==========================================
    // Checks
    task automatic chk(input logic [73:0] got, input logic [73:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_all();
        chk(channel_o, mdl[0]);
        chk(start_o, mdl[1]);
        chk(stop_o, mdl[2]);
        chk(step_o, mdl[3]);
        chk(ref_o, mdl[4]);
        chk(freq_o, mdl[1] + mdl[0] * mdl[3]);
    endtask
    task automatic frame(input logic [3:0] code, input logic [3:0] n, input logic [23:0] v,
        input int nb);
        logic [73:0] s;
        int          k;
        s = 74'(v);
        for (int i = 0; i < n; i++) s = s * 74'hA;
        host.send({code, n, v}, nb);
        k = 0;
        while (update_o !== 1'b1 && bad_code_o !== 1'b1 && k < 100) begin
            @(negedge mclk_i);
            k++;
        end
        if (nb == 32 && code < 5) mdl[code] = s;
        chk(update_o, nb == 32 && code < 5);
        chk(bad_code_o, nb == 32 && code > 4);
        @(negedge mclk_i);
        chk_all();
    endtask
    task automatic do_reset();
        rst_n_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 5; i++) mdl[i] = 74'h0;
        @(negedge mclk_i);
        chk_all();
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================
    // Sequence
    initial begin
        rst_n_i = 1'b0;
        do_reset();
        for (int i = 0; i < 16; i++) frame(4'(i % 5), 4'(i), 24'($random(seed)), 32);
        @(posedge mclk_i);
        do_reset();
        frame(4'h4, 4'h3, 24'($random(seed)), 32);
        frame(4'h5, 4'h2, 24'($random(seed)), 32);
        frame(4'hF, 4'h0, 24'($random(seed)), 32);
        frame(4'h3, 4'h1, 24'($random(seed)), 31);
        frame(4'h1, 4'h6, 24'($random(seed)), 32);
        finish_test();
    end
    initial begin
        repeat (40000) @(posedge mclk_i);
        num_errors++;
        finish_test();
    end
endmodule
